// file: pkg/rtc_pkg.sv
// Constants shared by the real time clock control and alarm logic
package rtc_pkg;
	// ----------------------------------------
	// Clocking
	// ----------------------------------------
	localparam int CLK_HZ = 40000000;
	localparam int WINDOW_US = 1000;
	localparam int WINDOW_CYCLES = (CLK_HZ / 1000000) * WINDOW_US;
	localparam int CLKS_PER_MACHINE_CYCLE = 4;
	localparam int SETUP_MACHINE_CYCLES = 4;
	localparam int SETUP_CYCLES = CLKS_PER_MACHINE_CYCLE * SETUP_MACHINE_CYCLES;
	localparam logic [6:0] XTAL_PER_TICK_LAST = 7'h7f;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_ALARM_SUBSECOND = 8'hf2;
	localparam logic [7:0] ADDR_ALARM_SECOND = 8'hf3;
	localparam logic [7:0] ADDR_ALARM_MINUTE = 8'hf4;
	localparam logic [7:0] ADDR_ALARM_HOUR = 8'hf5;
	localparam logic [7:0] ADDR_TIME_DAY_LOW = 8'hf6;
	localparam logic [7:0] ADDR_TIME_DAY_HIGH = 8'hf7;
	localparam logic [7:0] ADDR_TIME_SECOND = 8'hfa;
	localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'hf9;
	localparam logic [7:0] ADDR_TIME_SUBSECOND = 8'hfb;
	localparam logic [7:0] ADDR_TIME_MINUTE = 8'hfc;
	localparam logic [7:0] ADDR_TIME_HOUR = 8'hfd;
	// ----------------------------------------
	// Clock control fields
	// ----------------------------------------
	localparam int BIT_OSC_RUN = 0;
	localparam int BIT_ALARM_FLAG = 1;
	localparam int BIT_WRITE_LOCK = 2;
	localparam int BIT_READ_LOCK = 3;
	localparam int BIT_HOUR_CMP = 4;
	localparam int BIT_MIN_CMP = 5;
	localparam int BIT_SEC_CMP = 6;
	localparam int BIT_SUBSEC_CMP = 7;
	// ----------------------------------------
	// Time limits
	// ----------------------------------------
	localparam logic [5:0] SEC_LAST = 6'h3b;
	localparam logic [5:0] MIN_LAST = 6'h3b;
	localparam logic [4:0] HOUR_LAST = 5'h17;
	localparam logic [7:0] SUBSEC_LAST = 8'hff;
	localparam logic [7:0] ZERO8 = 8'h00;
endpackage

// file: tb/rtc_access_and_alarm_sva.sv
// Assertion checker for the real time clock access and alarm block
`timescale 1ns/1ps
module rtc_access_and_alarm_chk #(
	parameter int WINDOW_LEN = 64
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic batt_reset_n,
	input wire logic xtal_in,
	input wire logic osc_enable,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic timed_access_ok,
	input wire logic [7:0] sfr_rdata,
	input wire logic alarm_flag
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	logic ctl_wr;
	assign ctl_wr = sfr_wr && sfr_addr == rtc_pkg::ADDR_CLOCK_CONTROL;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n || !batt_reset_n);
	chk_cmp_off_clear: assert property (ctl_wr && sfr_wdata[7:4] == 4'h0 |-> ##2 !alarm_flag)
		else $error("alarm flag kept with all compares off");
	chk_osc_ta_write: assert property (ctl_wr && timed_access_ok |=> osc_enable == $past(sfr_wdata[0]))
		else $error("run enable not taken from timed write");
	chk_osc_no_ta: assert property (ctl_wr && !timed_access_ok |=> $stable(osc_enable))
		else $error("run enable changed without timed access");
	chk_op_reset_keep: assert property (disable iff (!batt_reset_n) !reset_n |=> !alarm_flag && osc_enable == $past(osc_enable))
		else $error("operational reset disturbed run enable");
	chk_batt_clear: assert property (disable iff (1'b0) !batt_reset_n |=> !osc_enable && !alarm_flag && sfr_rdata == 8'h00)
		else $error("battery reset left state defined nonzero");
	chk_flag_holds: assert property (alarm_flag && !ctl_wr && !$past(ctl_wr) |=> alarm_flag)
		else $error("alarm flag dropped without software clear");
	chk_flag_readback: assert property (!sfr_wr && sfr_addr == rtc_pkg::ADDR_CLOCK_CONTROL |=> sfr_rdata[1] == $past(alarm_flag))
		else $error("control readback disagrees with alarm flag");
	chk_alarm_readback: assert property ((sfr_wr && sfr_addr == rtc_pkg::ADDR_ALARM_SUBSECOND) ##1 (!sfr_wr && sfr_addr == rtc_pkg::ADDR_ALARM_SUBSECOND) |=> sfr_rdata == $past(sfr_wdata, 2))
		else $error("alarm subsecond readback wrong");
	cover property ($rose(alarm_flag));
	cover property (ctl_wr && timed_access_ok);
	cover property ($fell(osc_enable));
endmodule
bind rtc_access_and_alarm rtc_access_and_alarm_chk #(.WINDOW_LEN(WINDOW_LEN)) chk_u (.clk(clk), .reset_n(reset_n),
	.batt_reset_n(batt_reset_n), .xtal_in(xtal_in), .osc_enable(osc_enable), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_wdata(sfr_wdata), .timed_access_ok(timed_access_ok), .sfr_rdata(sfr_rdata), .alarm_flag(alarm_flag));

// file: tb/test_rtc_access_and_alarm.sv
// Self-checking testbench for the real time clock access and alarm block
`timescale 1ns/1ps
module test_rtc_access_and_alarm;
	localparam int WLEN = 64;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic batt_reset_n = 1'b0;
	logic xtal_in = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic timed_access_ok = 1'b0;
	logic osc_enable;
	logic [7:0] sfr_rdata;
	logic alarm_flag;
	int n_fail = 0;
	int n_tests = 0;
	logic [31:0] seed = 32'h18ce_0b37;
	logic [7:0] sec, min, hr, dow, v, v2;
	rtc_access_and_alarm #(.WINDOW_LEN(WLEN)) dut_u (.clk(clk), .reset_n(reset_n), .batt_reset_n(batt_reset_n),
		.xtal_in(xtal_in), .osc_enable(osc_enable), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.timed_access_ok(timed_access_ok), .sfr_rdata(sfr_rdata), .alarm_flag(alarm_flag));
	initial begin
		forever #12.5 clk = ~clk;
	end
	always #50 xtal_in = ~xtal_in;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [7:0] next_sec(input logic [7:0] s);
		return (s == 8'h3b) ? 8'h00 : s + 8'h01;
	endfunction
	task automatic draw(input int lim, output logic [7:0] r);
		seed = lfsr(seed);
		r = 8'(seed % lim);
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ta);
		sfr_addr = a;
		sfr_wdata = d;
		timed_access_ok = ta;
		sfr_wr = 1'b1;
		cycles(1);
		sfr_wr = 1'b0;
		timed_access_ok = 1'b0;
		cycles(1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sfr_addr = a;
		cycles(1);
		d = sfr_rdata;
	endtask
	task automatic wait_flag(input int lim);
		for (int i = 0; i < lim && alarm_flag !== 1'b1; i++) cycles(1);
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		wrap_up();
	end
	initial begin
		cycles(2);
		reset_n = 1'b1;
		batt_reset_n = 1'b1;
		rd(rtc_pkg::ADDR_CLOCK_CONTROL, v);
		chk("clock_control", 8'h00, v);
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'h05, 1'b0);
		rd(rtc_pkg::ADDR_CLOCK_CONTROL, v);
		chk("clock_control", 8'h00, v);
		rd(8'h00, v);
		chk("unmapped", 8'h00, v);
		for (int i = 0; i < 4; i++) begin
			draw((i == 0) ? 256 : (i == 3) ? 24 : 60, v);
			wr(rtc_pkg::ADDR_ALARM_SUBSECOND + 8'(i), v, 1'b0);
			rd(rtc_pkg::ADDR_ALARM_SUBSECOND + 8'(i), v2);
			chk("alarm register", v, v2);
		end
		draw(60, sec);
		draw(60, min);
		draw(24, hr);
		draw(8, dow);
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'h04, 1'b1);
		wr(rtc_pkg::ADDR_TIME_SECOND, sec, 1'b0);
		cycles(16);
		wr(rtc_pkg::ADDR_TIME_SECOND, sec, 1'b0);
		wr(rtc_pkg::ADDR_TIME_MINUTE, min, 1'b0);
		wr(rtc_pkg::ADDR_TIME_HOUR, {dow[2:0], hr[4:0]}, 1'b0);
		rd(rtc_pkg::ADDR_TIME_MINUTE, v);
		chk("time minute", min, v);
		rd(rtc_pkg::ADDR_TIME_HOUR, v);
		chk("time hour", {dow[2:0], hr[4:0]}, v);
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'h00, 1'b1);
		wr(rtc_pkg::ADDR_TIME_SECOND, next_sec(sec), 1'b0);
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'h04, 1'b1);
		wr(rtc_pkg::ADDR_TIME_SECOND, next_sec(sec), 1'b0);
		cycles(WLEN + 10);
		wr(rtc_pkg::ADDR_TIME_SECOND, next_sec(sec), 1'b0);
		rd(rtc_pkg::ADDR_TIME_SECOND, v);
		chk("time second", sec, v);
		rd(rtc_pkg::ADDR_CLOCK_CONTROL, v);
		chk("write lock", 8'h00, {7'h00, v[2]});
		wr(rtc_pkg::ADDR_ALARM_SUBSECOND, 8'h00, 1'b0);
		wr(rtc_pkg::ADDR_ALARM_SECOND, sec, 1'b0);
		wr(rtc_pkg::ADDR_ALARM_MINUTE, min, 1'b0);
		wr(rtc_pkg::ADDR_ALARM_HOUR, hr, 1'b0);
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'hf0, 1'b0);
		wait_flag(8);
		chk("alarm flag", 8'h01, {7'h00, alarm_flag});
		cycles(20);
		chk("alarm flag", 8'h01, {7'h00, alarm_flag});
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'h02, 1'b0);
		chk("alarm flag", 8'h00, {7'h00, alarm_flag});
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'hf0, 1'b0);
		cycles(4);
		chk("alarm flag", 8'h00, {7'h00, alarm_flag});
		wr(rtc_pkg::ADDR_ALARM_SUBSECOND, 8'h02, 1'b0);
		wr(rtc_pkg::ADDR_ALARM_SECOND, next_sec(sec), 1'b0);
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'h81, 1'b1);
		wait_flag(3000);
		chk("alarm flag", 8'h01, {7'h00, alarm_flag});
		rd(rtc_pkg::ADDR_TIME_SUBSECOND, v);
		chk("time subsecond", 8'h02, v);
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'h88, 1'b0);
		cycles(16);
		rd(rtc_pkg::ADDR_TIME_SUBSECOND, v);
		chk("locked subsecond", 8'h02, v);
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'h80, 1'b0);
		cycles(467);
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'h88, 1'b0);
		cycles(30);
		rd(rtc_pkg::ADDR_TIME_SUBSECOND, v);
		chk("held subsecond", 8'h02, v);
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'h80, 1'b0);
		rd(rtc_pkg::ADDR_TIME_SUBSECOND, v);
		chk("released subsecond", 8'h03, v);
		reset_n = 1'b0;
		cycles(2);
		reset_n = 1'b1;
		chk("osc_enable", 8'h01, {7'h00, osc_enable});
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'h80, 1'b1);
		rd(rtc_pkg::ADDR_TIME_SUBSECOND, v);
		cycles(1200);
		rd(rtc_pkg::ADDR_TIME_SUBSECOND, v2);
		chk("stopped subsecond", v, v2);
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'h04, 1'b1);
		cycles(16);
		wr(rtc_pkg::ADDR_TIME_SUBSECOND, 8'h55, 1'b0);
		rd(rtc_pkg::ADDR_TIME_SUBSECOND, v);
		chk("time subsecond", 8'h03, v);
		wr(rtc_pkg::ADDR_CLOCK_CONTROL, 8'h00, 1'b1);
		rd(rtc_pkg::ADDR_TIME_SUBSECOND, v);
		chk("time subsecond", 8'h00, v);
		wrap_up();
	end
endmodule

// file: verilog/rtc_access_and_alarm.sv
// Real time clock lock windows, timekeeping and alarm logic
`timescale 1ns/1ps
module rtc_access_and_alarm #(
	parameter int WINDOW_LEN = rtc_pkg::WINDOW_CYCLES
) (
	// Clock and resets
	input wire logic clk,
	input wire logic reset_n,
	input wire logic batt_reset_n,
	// Crystal
	input wire logic xtal_in,
	output logic osc_enable,
	// Special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic timed_access_ok,
	output logic [7:0] sfr_rdata,
	// Alarm
	output logic alarm_flag
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic xtal_s1_reg, xtal_s2_reg, xtal_s3_reg;
	logic osc_run_enable_reg, osc_run_enable_next;
	logic time_read_lock_reg, time_read_lock_next;
	logic time_write_lock_reg, time_write_lock_next;
	logic alarm_flag_reg, alarm_flag_next;
	logic [3:0] cmp_en_reg, cmp_en_next;
	logic [6:0] prescale_reg, prescale_next;
	logic tick_pending_reg, tick_pending_next;
	logic alarm_done_reg, alarm_done_next;
	logic [31:0] lock_cnt_reg, lock_cnt_next;
	logic [7:0] time_subsecond_reg, time_subsecond_next;
	logic [5:0] time_second_reg, time_second_next;
	logic [5:0] time_minute_reg, time_minute_next;
	logic [4:0] time_hour_reg, time_hour_next;
	logic [2:0] day_of_week_reg, day_of_week_next;
	logic [15:0] day_count_reg, day_count_next;
	logic [7:0] alarm_subsecond_reg, alarm_subsecond_next;
	logic [5:0] alarm_second_reg, alarm_second_next;
	logic [5:0] alarm_minute_reg, alarm_minute_next;
	logic [4:0] alarm_hour_reg, alarm_hour_next;
	logic [7:0] rdata_reg, rdata_next;

	logic any_lock, suspended, write_open, wr_ctrl, match, any_cmp;

	function automatic logic hit(input logic en, input logic [7:0] a, input logic [7:0] b);
		hit = !en || (a == b);
	endfunction

	// ----------------------------------------
	// Crystal input synchroniser
	// ----------------------------------------
	always_ff @(posedge clk) begin
		xtal_s1_reg <= xtal_in;
		xtal_s2_reg <= xtal_s1_reg;
		xtal_s3_reg <= xtal_s2_reg;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		osc_run_enable_next = osc_run_enable_reg;
		time_read_lock_next = time_read_lock_reg;
		time_write_lock_next = time_write_lock_reg;
		alarm_flag_next = alarm_flag_reg;
		cmp_en_next = cmp_en_reg;
		prescale_next = prescale_reg;
		tick_pending_next = tick_pending_reg;
		alarm_done_next = alarm_done_reg;
		lock_cnt_next = lock_cnt_reg;
		time_subsecond_next = time_subsecond_reg;
		time_second_next = time_second_reg;
		time_minute_next = time_minute_reg;
		time_hour_next = time_hour_reg;
		day_of_week_next = day_of_week_reg;
		day_count_next = day_count_reg;
		alarm_subsecond_next = alarm_subsecond_reg;
		alarm_second_next = alarm_second_reg;
		alarm_minute_next = alarm_minute_reg;
		alarm_hour_next = alarm_hour_reg;

		any_lock = time_read_lock_reg || time_write_lock_reg;
		suspended = any_lock && (lock_cnt_reg < 32'(WINDOW_LEN));
		write_open = time_write_lock_reg && (lock_cnt_reg >= 32'(rtc_pkg::SETUP_CYCLES))
			&& (lock_cnt_reg < 32'(WINDOW_LEN));
		wr_ctrl = sfr_wr && (sfr_addr == rtc_pkg::ADDR_CLOCK_CONTROL);

		// Lock window timer
		if (!any_lock) begin
			lock_cnt_next = '0;
		end else if (lock_cnt_reg < 32'(WINDOW_LEN)) begin
			lock_cnt_next = lock_cnt_reg + 32'd1;
		end

		// Crystal prescaler, stopped with the oscillator
		if (osc_run_enable_reg && xtal_s2_reg && !xtal_s3_reg) begin
			prescale_next = prescale_reg + 7'd1;
			if (prescale_reg == rtc_pkg::XTAL_PER_TICK_LAST) begin
				tick_pending_next = 1'b1;
			end
		end

		// Timekeeping on a held or fresh tick
		if (tick_pending_reg && !suspended) begin
			tick_pending_next = 1'b0;
			alarm_done_next = 1'b0;
			time_subsecond_next = time_subsecond_reg + 8'd1;
			if (time_subsecond_reg == rtc_pkg::SUBSEC_LAST) begin
				time_second_next = time_second_reg + 6'd1;
				if (time_second_reg == rtc_pkg::SEC_LAST) begin
					time_second_next = '0;
					time_minute_next = time_minute_reg + 6'd1;
					if (time_minute_reg == rtc_pkg::MIN_LAST) begin
						time_minute_next = '0;
						time_hour_next = time_hour_reg + 5'd1;
						if (time_hour_reg == rtc_pkg::HOUR_LAST) begin
							time_hour_next = '0;
							day_of_week_next = day_of_week_reg + 3'd1;
							day_count_next = day_count_reg + 16'd1;
						end
					end
				end
			end
		end

		// Software writes to time registers
		if (sfr_wr && write_open) begin
			unique case (sfr_addr)
				rtc_pkg::ADDR_TIME_SECOND: time_second_next = sfr_wdata[5:0];
				rtc_pkg::ADDR_TIME_MINUTE: time_minute_next = sfr_wdata[5:0];
				rtc_pkg::ADDR_TIME_HOUR: begin
					time_hour_next = sfr_wdata[4:0];
					day_of_week_next = sfr_wdata[7:5];
				end
				rtc_pkg::ADDR_TIME_DAY_LOW: day_count_next[7:0] = sfr_wdata;
				rtc_pkg::ADDR_TIME_DAY_HIGH: day_count_next[15:8] = sfr_wdata;
				default: ;
			endcase
		end

		// Alarm registers, no lock needed
		if (sfr_wr) begin
			unique case (sfr_addr)
				rtc_pkg::ADDR_ALARM_SUBSECOND: alarm_subsecond_next = sfr_wdata;
				rtc_pkg::ADDR_ALARM_SECOND: alarm_second_next = sfr_wdata[5:0];
				rtc_pkg::ADDR_ALARM_MINUTE: alarm_minute_next = sfr_wdata[5:0];
				rtc_pkg::ADDR_ALARM_HOUR: alarm_hour_next = sfr_wdata[4:0];
				default: ;
			endcase
		end

		// Clock control writes
		if (wr_ctrl) begin
			cmp_en_next = sfr_wdata[rtc_pkg::BIT_SUBSEC_CMP:rtc_pkg::BIT_HOUR_CMP];
			time_read_lock_next = sfr_wdata[rtc_pkg::BIT_READ_LOCK];
			if (!sfr_wdata[rtc_pkg::BIT_ALARM_FLAG]) begin
				alarm_flag_next = 1'b0;
			end
			if (timed_access_ok) begin
				time_write_lock_next = sfr_wdata[rtc_pkg::BIT_WRITE_LOCK];
				osc_run_enable_next = sfr_wdata[rtc_pkg::BIT_OSC_RUN];
			end
		end

		// Write window expiry
		if (time_write_lock_reg && lock_cnt_reg >= 32'(WINDOW_LEN)) begin
			time_write_lock_next = 1'b0;
		end
		if (time_write_lock_reg && !time_write_lock_next) begin
			time_subsecond_next = rtc_pkg::ZERO8;
		end

		// Alarm comparator on live values
		any_cmp = |cmp_en_reg;
		match = hit(cmp_en_reg[3], time_subsecond_reg, alarm_subsecond_reg)
			&& hit(cmp_en_reg[2], {2'b00, time_second_reg}, {2'b00, alarm_second_reg})
			&& hit(cmp_en_reg[1], {2'b00, time_minute_reg}, {2'b00, alarm_minute_reg})
			&& hit(cmp_en_reg[0], {3'b000, time_hour_reg}, {3'b000, alarm_hour_reg});
		if (any_cmp && match && !alarm_done_reg && !(tick_pending_reg && !suspended)) begin
			alarm_flag_next = 1'b1;
			alarm_done_next = 1'b1;
		end
		if (!any_cmp) begin
			alarm_flag_next = 1'b0;
		end

		// Read data
		unique case (sfr_addr)
			rtc_pkg::ADDR_ALARM_SUBSECOND: rdata_next = alarm_subsecond_reg;
			rtc_pkg::ADDR_ALARM_SECOND: rdata_next = {2'b00, alarm_second_reg};
			rtc_pkg::ADDR_ALARM_MINUTE: rdata_next = {2'b00, alarm_minute_reg};
			rtc_pkg::ADDR_ALARM_HOUR: rdata_next = {3'b000, alarm_hour_reg};
			rtc_pkg::ADDR_CLOCK_CONTROL: rdata_next = {cmp_en_reg, time_read_lock_reg,
				time_write_lock_reg, alarm_flag_reg, osc_run_enable_reg};
			rtc_pkg::ADDR_TIME_SUBSECOND: rdata_next = time_subsecond_reg;
			rtc_pkg::ADDR_TIME_SECOND: rdata_next = {2'b00, time_second_reg};
			rtc_pkg::ADDR_TIME_MINUTE: rdata_next = {2'b00, time_minute_reg};
			rtc_pkg::ADDR_TIME_HOUR: rdata_next = {day_of_week_reg, time_hour_reg};
			rtc_pkg::ADDR_TIME_DAY_LOW: rdata_next = day_count_reg[7:0];
			rtc_pkg::ADDR_TIME_DAY_HIGH: rdata_next = day_count_reg[15:8];
			default: rdata_next = rtc_pkg::ZERO8;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!batt_reset_n) begin
			osc_run_enable_reg <= 1'b0;
			cmp_en_reg <= '0;
			prescale_reg <= '0;
			time_subsecond_reg <= '0;
			time_second_reg <= '0;
			time_minute_reg <= '0;
			time_hour_reg <= '0;
			day_of_week_reg <= '0;
			day_count_reg <= '0;
			alarm_subsecond_reg <= '0;
			alarm_second_reg <= '0;
			alarm_minute_reg <= '0;
			alarm_hour_reg <= '0;
		end else begin
			osc_run_enable_reg <= osc_run_enable_next;
			cmp_en_reg <= cmp_en_next;
			prescale_reg <= prescale_next;
			time_subsecond_reg <= time_subsecond_next;
			time_second_reg <= time_second_next;
			time_minute_reg <= time_minute_next;
			time_hour_reg <= time_hour_next;
			day_of_week_reg <= day_of_week_next;
			day_count_reg <= day_count_next;
			alarm_subsecond_reg <= alarm_subsecond_next;
			alarm_second_reg <= alarm_second_next;
			alarm_minute_reg <= alarm_minute_next;
			alarm_hour_reg <= alarm_hour_next;
		end
		if (!reset_n || !batt_reset_n) begin
			time_read_lock_reg <= 1'b0;
			time_write_lock_reg <= 1'b0;
			alarm_flag_reg <= 1'b0;
			tick_pending_reg <= 1'b0;
			alarm_done_reg <= 1'b0;
			lock_cnt_reg <= '0;
			rdata_reg <= '0;
		end else begin
			time_read_lock_reg <= time_read_lock_next;
			time_write_lock_reg <= time_write_lock_next;
			alarm_flag_reg <= alarm_flag_next;
			tick_pending_reg <= tick_pending_next;
			alarm_done_reg <= alarm_done_next;
			lock_cnt_reg <= lock_cnt_next;
			rdata_reg <= rdata_next;
		end
	end

	assign osc_enable = osc_run_enable_reg;
	assign alarm_flag = alarm_flag_reg;
	assign sfr_rdata = rdata_reg;
endmodule
